// *** hw/mal_pkg.sv ***
package mal_pkg;

	// ********************************************************************
	// Address space
	// ********************************************************************
	localparam int          ADDR_W          = 11;
	localparam int          DATA_W          = 8;
	localparam logic [10:0] APP_BASE        = 11'h000;
	localparam logic [10:0] MEAS_TOP        = 11'h3FF;
	localparam logic [10:0] SYS_EE_BASE     = 11'h400;
	localparam logic [10:0] SYS_EE_TOP      = 11'h43F;
	localparam logic [10:0] FAC_EE_BASE     = 11'h440;
	localparam logic [10:0] FAC_EE_TOP      = 11'h47F;
	localparam logic [10:0] SYS_MIR_BASE    = 11'h600;
	localparam logic [10:0] SYS_MIR_TOP     = 11'h63F;
	localparam logic [10:0] FAC_MIR_BASE    = 11'h640;
	localparam logic [10:0] FAC_MIR_TOP     = 11'h67F;
	localparam logic [10:0] FAC_VOL_BASE    = 11'h740;
	localparam logic [10:0] FAC_VOL_TOP     = 11'h77F;
	localparam logic [10:0] LOCK_BASE       = 11'h460;
	localparam logic [7:0]  APP_ALL         = 8'hFF;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [6:0]  BOOT_LAST       = 7'h7F;
	localparam logic [6:0]  BOOT_FIRST      = 7'h00;
	localparam logic [31:0] FAC_PASSWORD    = 32'h5A3C_96E1;
	localparam int          READ_LATENCY    = 3;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef enum logic [1:0] {SRC_RFID, SRC_SPI, SRC_LOG} mal_src_type;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOCK} mal_op_type;
	typedef enum logic [2:0] {
		RG_APP, RG_MEAS, RG_SYS_EE, RG_SYS_MIR, RG_SYS_VOL,
		RG_FAC_EE, RG_FAC_MIR, RG_FAC_VOL
	} mal_region_type;
	typedef enum logic [2:0] {
		PH_BOOT_RD, PH_BOOT_WAIT, PH_BOOT_CAP, PH_IDLE, PH_RD_WAIT, PH_RD_CAP
	} mal_phase_type;

	typedef struct packed {
		logic        valid;
		mal_src_type src;
		mal_op_type  op;
		logic [10:0] addr;
		logic [7:0]  wdata;
	} mal_req_type;

	typedef struct packed {
		logic        valid;
		logic [2:0]  levels;
	} mal_grant_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] password;
	} mal_unlock_type;

	typedef struct packed {
		logic        en;
		logic        we;
		logic        bitset;
		logic [10:0] addr;
		logic [7:0]  wdata;
	} mal_mem_type;

	typedef struct packed {
		logic        done;
		logic        rd_valid;
		logic        refused;
		logic        pw_err;
		logic [7:0]  rdata;
	} mal_resp_type;

endpackage

// *** hw/mal_access_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// - Application is 0x000 to 4*count+3, readable
// - RFID application write needs application grant
// - SPI writes to non-factory always allowed
// - Measurement is 4*count+4 to 0x3FF unless 255
// - RFID measurement write needs measurement grant
// - Logger writes measurement without any grant
// - RFID system write needs grant; reads free
// - System EEPROM 0x400-0x43F readable and writable
// - System mirror 0x600-0x63F write-only, reads zero
// - RFID factory write dropped with password error, refused flag low
// - RFID factory read gives zero, no error
// - SPI factory read always; write when unlocked
// - Matching unlock password opens factory access
// - Locked factory SPI writes silently dropped
// - Factory EEPROM 0x440-0x47F SPI read/write
// - Factory mirror 0x640-0x67F write-only, reads zero
// - Factory volatile 0x740-0x77F write-only, reads zero
// - Mirrors loaded from EEPROM after reset
// - RFID lock command sets bits, RFID reads zero, SPI can read them
// - Bit 10 low selects application/measurement EEPROM
// - Bit 6 picks system or factory above
// - Ignored address bits alias to same storage
// - Block count holds blocks minus one
module mal_access_ctrl
	import mal_pkg::*;
(
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// Configuration
	input  wire logic [7:0]     app_block_count_i,
	// Commands
	input  wire mal_req_type    req_i,
	input  wire mal_grant_type  grant_i,
	input  wire mal_unlock_type unlock_i,
	// Storage port
	input  wire logic [7:0]     mem_rdata_i,
	output mal_mem_type         mem_o,
	// Answers and status
	output logic                req_ready_o,
	output mal_resp_type        resp_o,
	output logic [2:0]          grants_o,
	output logic                fac_open_o,
	output logic                boot_busy_o
);

	typedef struct packed {
		mal_phase_type phase;
		logic [6:0]    boot_idx;
		logic          ready;
		logic          boot_busy;
		logic [2:0]    grants;
		logic          fac_open;
		mal_mem_type   mem;
		mal_resp_type  resp;
	} mal_state_type;

	mal_state_type  st;
	mal_state_type  next_st;
	mal_region_type req_region;
	logic [10:0]    req_addr;
	logic           req_take;

	// ********************************************************************
	// Address decode
	// ********************************************************************
	function automatic mal_region_type region_of(input logic [10:0] a,
		input logic [7:0] blocks);
		mal_region_type r;
		r = RG_APP;
		if (!a[10]) begin
			if ((blocks == APP_ALL) || (a[9:2] <= blocks)) begin
				r = RG_APP;
			end else begin
				r = RG_MEAS;
			end
		end else if (!a[9]) begin
			r = a[6] ? RG_FAC_EE : RG_SYS_EE;
		end else if (!a[8]) begin
			r = a[6] ? RG_FAC_MIR : RG_SYS_MIR;
		end else begin
			r = a[6] ? RG_FAC_VOL : RG_SYS_VOL;
		end
		return r;
	endfunction

	// Fold the ignored bits so every alias hits one storage location
	function automatic logic [10:0] canon(input logic [10:0] a);
		logic [10:0] c;
		c = a;
		if (a[10] && !a[9]) begin
			c = {2'b10, 2'b00, a[6:0]};
		end else if (a[10]) begin
			c = {2'b11, a[8], 1'b0, a[6:0]};
		end
		return c;
	endfunction

	function automatic logic is_factory(input mal_region_type r);
		return (r == RG_FAC_EE) || (r == RG_FAC_MIR) || (r == RG_FAC_VOL);
	endfunction

	// Mirror windows and the factory volatile window never return their contents
	function automatic logic reads_zero(input mal_region_type r, input mal_src_type s);
		return (r == RG_SYS_MIR) || (r == RG_FAC_MIR) || (r == RG_FAC_VOL)
			|| (is_factory(r) && (s == SRC_RFID));
	endfunction

	assign req_region = region_of(req_i.addr, app_block_count_i);
	assign req_addr   = canon(req_i.addr);
	assign req_take   = req_i.valid && st.ready;

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		logic allow;
		logic pw_err;
		allow  = 1'b0;
		pw_err = 1'b0;
		next_st = st;
		next_st.mem.en   = 1'b0;
		next_st.mem.we   = 1'b0;
		next_st.mem.bitset = 1'b0;
		next_st.resp.done = 1'b0;
		next_st.resp.rd_valid = 1'b0;
		next_st.resp.refused = 1'b0;
		next_st.resp.pw_err = 1'b0;

		// Grant and unlock commands act in any phase
		if (grant_i.valid) begin
			next_st.grants = grant_i.levels;
		end
		if (unlock_i.valid && (unlock_i.password == FAC_PASSWORD)) begin
			next_st.fac_open = 1'b1;
		end

		if (req_take) begin
			case (req_i.op)
				OP_READ: begin
					if (reads_zero(req_region, req_i.src)) begin
						next_st.resp.done = 1'b1;
						next_st.resp.rd_valid = 1'b1;
						next_st.resp.rdata = ZERO_BYTE;
					end else begin
						next_st.mem.en   = 1'b1;
						next_st.mem.addr = req_addr;
						next_st.phase    = PH_RD_WAIT;
					end
				end
				OP_WRITE: begin
					case (req_i.src)
						SRC_RFID: begin
							case (req_region)
								RG_APP:  allow = st.grants[0];
								RG_MEAS: allow = st.grants[1];
								RG_SYS_EE, RG_SYS_MIR, RG_SYS_VOL: begin
									allow = st.grants[2];
								end
								default: pw_err = 1'b1;
							endcase
						end
						SRC_SPI: begin
							allow = is_factory(req_region) ? st.fac_open : 1'b1;
						end
						default: begin
							allow = (req_region == RG_MEAS);
						end
					endcase
					next_st.resp.done = 1'b1;
					next_st.resp.pw_err = pw_err;
					// Locked factory writes from SPI are dropped without a flag
					next_st.resp.refused = !allow && !pw_err
						&& !((req_i.src == SRC_SPI) && is_factory(req_region));
					if (allow) begin
						next_st.mem.en    = 1'b1;
						next_st.mem.we    = 1'b1;
						next_st.mem.addr  = req_addr;
						next_st.mem.wdata = req_i.wdata;
					end
				end
				OP_LOCK: begin
					// Lock bit for block n sits at byte n/8, bit n%8
					next_st.resp.done   = 1'b1;
					next_st.mem.en      = 1'b1;
					next_st.mem.we      = 1'b1;
					next_st.mem.bitset  = 1'b1;
					next_st.mem.addr    = 11'(LOCK_BASE + {6'h00, req_i.wdata[7:3]});
					next_st.mem.wdata   = 8'h01 << req_i.wdata[2:0];
				end
				default: begin
					next_st.resp.done    = 1'b1;
					next_st.resp.refused = 1'b1;
				end
			endcase
		end

		case (st.phase)
			PH_BOOT_RD: begin
				next_st.mem.en   = 1'b1;
				next_st.mem.addr = SYS_EE_BASE | {4'h0, st.boot_idx};
				next_st.phase    = PH_BOOT_WAIT;
			end
			PH_BOOT_WAIT: begin
				next_st.phase = PH_BOOT_CAP;
			end
			PH_BOOT_CAP: begin
				next_st.mem.en    = 1'b1;
				next_st.mem.we    = 1'b1;
				next_st.mem.addr  = SYS_MIR_BASE | {4'h0, st.boot_idx};
				next_st.mem.wdata = mem_rdata_i;
				next_st.boot_idx  = 7'(st.boot_idx + 7'h01);
				next_st.phase     = (st.boot_idx == BOOT_LAST) ? PH_IDLE : PH_BOOT_RD;
			end
			PH_RD_WAIT: begin
				next_st.phase = PH_RD_CAP;
			end
			PH_RD_CAP: begin
				next_st.resp.done     = 1'b1;
				next_st.resp.rd_valid = 1'b1;
				next_st.resp.rdata    = mem_rdata_i;
				next_st.phase         = PH_IDLE;
			end
			PH_IDLE: begin
			end
			default: begin
				next_st.phase = PH_IDLE;
			end
		endcase
		next_st.boot_busy = next_st.phase inside {PH_BOOT_RD, PH_BOOT_WAIT, PH_BOOT_CAP};
		next_st.ready = (next_st.phase == PH_IDLE);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st.phase    <= PH_BOOT_RD;
			st.boot_idx <= BOOT_FIRST;
			st.ready    <= 1'b0;
			st.boot_busy <= 1'b1;
			st.grants   <= 3'h0;
			st.fac_open <= 1'b0;
			st.mem      <= '0;
			st.resp     <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign mem_o       = st.mem;
	assign resp_o      = st.resp;
	assign req_ready_o = st.ready;
	assign grants_o    = st.grants;
	assign fac_open_o  = st.fac_open;
	assign boot_busy_o = st.boot_busy;

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rfid_wr(int lvl_unused);
		req_take && (req_i.src == SRC_RFID) && (req_i.op == OP_WRITE);
	endsequence

	a_app_wr_grant: assert property (
		s_rfid_wr(0) and (req_region == RG_APP) and !st.grants[0]
		|=> resp_o.done && resp_o.refused && !mem_o.we)
		else $error("RFID application write passed without grant");

	a_meas_wr_grant: assert property (
		s_rfid_wr(0) and (req_region == RG_MEAS) and st.grants[1]
		|=> mem_o.we && (mem_o.addr == $past(req_i.addr)))
		else $error("Granted measurement write not issued");

	a_spi_sys_write: assert property (
		req_take && (req_i.src == SRC_SPI) && (req_i.op == OP_WRITE)
		&& !is_factory(req_region) |=> mem_o.we && !resp_o.refused)
		else $error("SPI write to open region blocked");

	a_log_meas_wr: assert property (
		req_take && (req_i.src == SRC_LOG) && (req_i.op == OP_WRITE)
		&& (req_region == RG_MEAS) |=> mem_o.we && !resp_o.refused)
		else $error("Logger write to measurement blocked");

	a_fac_rfid_err: assert property (
		s_rfid_wr(0) and is_factory(req_region)
		|=> resp_o.pw_err && !mem_o.en)
		else $error("RFID factory write without password error");

	a_fac_spi_drop: assert property (
		req_take && (req_i.src == SRC_SPI) && (req_i.op == OP_WRITE)
		&& is_factory(req_region) && !fac_open_o
		|=> resp_o.done && !mem_o.en && !resp_o.refused && !resp_o.pw_err)
		else $error("Locked factory write not silently dropped");

	sequence s_zero_read;
		req_take && (req_i.op == OP_READ) && reads_zero(req_region, req_i.src);
	endsequence

	a_zero_reads: assert property (
		s_zero_read |=> resp_o.rd_valid && (resp_o.rdata == ZERO_BYTE)
		&& !mem_o.en && !resp_o.pw_err)
		else $error("Hidden region read did not return zero");

	sequence s_mem_read;
		req_take && (req_i.op == OP_READ) && !reads_zero(req_region, req_i.src);
	endsequence

	a_mem_read_lat: assert property (
		s_mem_read |=> mem_o.en && !mem_o.we ##1 !resp_o.done ##1
		resp_o.rd_valid && (resp_o.rdata == $past(mem_rdata_i)))
		else $error("Storage read answer timing wrong");

	a_unlock_opens: assert property (
		unlock_i.valid && (unlock_i.password == FAC_PASSWORD) |=> fac_open_o)
		else $error("Factory access not opened by password");

	a_alias_fold: assert property (
		req_take && (req_i.op == OP_WRITE) && req_i.addr[10] && !req_i.addr[9]
		&& mem_o.en == 1'b0 ##1 mem_o.we |-> mem_o.addr[8:7] == 2'b00)
		else $error("Upper EEPROM alias not folded");

	a_boot_copy: assert property (
		(st.phase == PH_BOOT_CAP) |=> mem_o.we
		&& (mem_o.addr[10:9] == 2'b11) && (mem_o.wdata == $past(mem_rdata_i)))
		else $error("Mirror load did not copy EEPROM byte");

	a_lock_bitset: assert property (
		req_take && (req_i.op == OP_LOCK)
		|=> mem_o.we && mem_o.bitset && resp_o.done && !resp_o.refused
		&& (mem_o.addr[10:5] == LOCK_BASE[10:5])
		&& (mem_o.addr[4:0] == $past(req_i.wdata[7:3]))
		&& (mem_o.wdata == (8'h01 << $past(req_i.wdata[2:0]))))
		else $error("Lock command did not set its bit");

	a_fac_spi_read: assert property (
		req_take && (req_i.src == SRC_SPI) && (req_i.op == OP_READ)
		&& (req_region == RG_FAC_EE) |=> mem_o.en && !mem_o.we && !resp_o.done)
		else $error("SPI factory read not sent to storage");

	a_boot_no_take: assert property (
		boot_busy_o |-> !req_ready_o && !resp_o.done)
		else $error("Request path open during mirror load");

endmodule

// *** test/mal_mem_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Byte storage behind the access block
// ****************************************
module mal_mem_model
	import mal_pkg::*;
(
	// Clock
	input  wire logic        clk_i,
	// Storage port
	input  wire mal_mem_type mem_i,
	output logic [7:0]       rdata_o
);
	logic [7:0] mem [0:2047];

	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = i[7:0] ^ 8'h5A;
		end
		rdata_o = 8'hA5;
	end

	// Read data is good for one cycle only; it toggles after so a late sample shows
	always @(posedge clk_i) begin
		if (mem_i.en && mem_i.we && mem_i.bitset) begin
			mem[mem_i.addr] <= mem[mem_i.addr] | mem_i.wdata;
		end else if (mem_i.en && mem_i.we) begin
			mem[mem_i.addr] <= mem_i.wdata;
		end
		if (mem_i.en && !mem_i.we) begin
			rdata_o <= mem[mem_i.addr];
		end else begin
			rdata_o <= ~rdata_o;
		end
	end
endmodule

// *** test/mal_access_ctrl_tb_top.sv ***
`timescale 1ns/1ps
// ****************************************
// Self-checking bench
// ****************************************
module mal_access_ctrl_tb_top;
	import mal_pkg::*;
	localparam logic [10:0] E_OK  = 11'h000;
	localparam logic [10:0] E_REF = 11'h400;
	localparam logic [10:0] E_PW  = 11'h200;
	localparam logic [10:0] E_RD  = 11'h100;

	logic           clk_i = 1'b0;
	logic           rst_i = 1'b1;
	logic [7:0]     app_block_count_i = 8'h00;
	mal_req_type    req_i = '0;
	mal_grant_type  grant_i = '0;
	mal_unlock_type unlock_i = '0;
	logic [7:0]     mem_rdata;
	mal_mem_type    mem_w;
	logic           req_ready_o;
	mal_resp_type   resp_o;
	logic [2:0]     grants_o;
	logic           fac_open_o;
	logic           boot_busy_o;
	int             err_total = 0;
	int             cmp_count = 0;
	logic [10:0]    exp_q[$];
	logic [31:0]    seed = 32'h2941;
	logic [7:0]     d;
	logic [10:0]    ta;
	logic [10:0]    note;

	always #20 clk_i = ~clk_i;

	mal_access_ctrl mal_access_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
		.app_block_count_i(app_block_count_i), .req_i(req_i), .grant_i(grant_i),
		.unlock_i(unlock_i), .mem_rdata_i(mem_rdata), .mem_o(mem_w),
		.req_ready_o(req_ready_o), .resp_o(resp_o), .grants_o(grants_o),
		.fac_open_o(fac_open_o), .boot_busy_o(boot_busy_o));
	mal_mem_model mal_mem_model_i (.clk_i(clk_i), .mem_i(mem_w), .rdata_o(mem_rdata));

	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function automatic logic [7:0] ib(logic [10:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction

	task automatic complete_run;
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_flag(string nm, logic e, logic g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask

	// Takes the oldest note whenever an answer appears
	always @(negedge clk_i) begin
		if (resp_o.done === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk_flag("unexpected done", 1'b0, 1'b1);
			end else begin
				note = exp_q.pop_front();
				chk_flag("refused", note[10], resp_o.refused);
				chk_flag("pw_err", note[9], resp_o.pw_err);
				chk_flag("rd_valid", note[8], resp_o.rd_valid);
				if (note[8]) begin
					chk_byte("rdata", note[7:0], resp_o.rdata);
				end
			end
		end
	end

	task automatic rq(mal_src_type s, mal_op_type o, logic [10:0] a, logic [7:0] w,
		logic [10:0] e);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 600) begin
			@(negedge clk_i);
			n++;
		end
		chk_flag("req_ready", 1'b1, req_ready_o);
		req_i = '{1'b1, s, o, a, w};
		exp_q.push_back(e);
		@(negedge clk_i);
	endtask

	task automatic idle;
		req_i.valid = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic gr(logic [2:0] m);
		grant_i = '{1'b1, m};
		@(negedge clk_i);
		grant_i.valid = 1'b0;
		@(negedge clk_i);
		chk_byte("grants", {5'h00, m}, {5'h00, grants_o});
	endtask

	task automatic ul(logic [31:0] p, logic e);
		unlock_i = '{1'b1, p};
		@(negedge clk_i);
		unlock_i.valid = 1'b0;
		@(negedge clk_i);
		chk_flag("fac_open", e, fac_open_o);
	endtask

	initial begin
		#800000;
		err_total++;
		$display("FAIL watchdog expected finish seen hang");
		complete_run();
	end

	initial begin
		repeat (5) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		chk_byte("grants reset", 8'h00, {5'h00, grants_o});
		chk_flag("fac_open reset", 1'b0, fac_open_o);
		chk_flag("boot_busy start", 1'b1, boot_busy_o);
		seed = xs(seed);
		app_block_count_i = (seed[7:0] == 8'hFF) ? 8'h3C : seed[7:0];
		ta = {1'b0, app_block_count_i, 2'b11};
		seed = xs(seed);
		d = seed[7:0] | 8'h80;
		rq(SRC_RFID, OP_WRITE, ta, d, E_REF);
		chk_flag("boot_busy", 1'b0, boot_busy_o);
		chk_byte("boot low", ib(11'h400), mal_mem_model_i.mem[11'h600]);
		chk_byte("boot high", ib(11'h47F), mal_mem_model_i.mem[11'h67F]);
		rq(SRC_RFID, OP_WRITE, ta + 11'h1, d, E_REF);
		rq(SRC_LOG, OP_WRITE, ta + 11'h1, d, E_OK);
		rq(SRC_LOG, OP_WRITE, ta, d, E_REF);
		rq(SRC_SPI, OP_WRITE, ta, d, E_OK);
		rq(SRC_RFID, OP_READ, ta, 8'h00, E_RD | d);
		rq(SRC_SPI, OP_READ, ta + 11'h1, 8'h00, E_RD | d);
		idle();
		gr(3'b001);
		rq(SRC_RFID, OP_WRITE, ta, ~d, E_OK);
		rq(SRC_RFID, OP_WRITE, ta + 11'h1, ~d, E_REF);
		rq(SRC_RFID, OP_WRITE, 11'h410, d, E_REF);
		rq(SRC_SPI, OP_READ, ta, 8'h00, E_RD | {3'b000, ~d});
		idle();
		gr(3'b010);
		rq(SRC_RFID, OP_WRITE, ta + 11'h1, ~d, E_OK);
		rq(SRC_RFID, OP_READ, ta + 11'h1, 8'h00, E_RD | {3'b000, ~d});
		idle();
		gr(3'b100);
		rq(SRC_RFID, OP_WRITE, 11'h43F, d, E_OK);
		rq(SRC_RFID, OP_READ, 11'h43F, 8'h00, E_RD | d);
		rq(SRC_RFID, OP_WRITE, 11'h605, d, E_OK);
		rq(SRC_RFID, OP_READ, 11'h605, 8'h00, E_RD);
		rq(SRC_SPI, OP_READ, 11'h605, 8'h00, E_RD);
		rq(SRC_RFID, OP_WRITE, 11'h720, d, E_OK);
		rq(SRC_SPI, OP_READ, 11'h7A0, 8'h00, E_RD | d);
		rq(SRC_RFID, OP_WRITE, 11'h450, d, E_PW);
		rq(SRC_RFID, OP_READ, 11'h450, 8'h00, E_RD);
		rq(SRC_SPI, OP_WRITE, 11'h450, d, E_OK);
		rq(SRC_SPI, OP_READ, 11'h450, 8'h00, E_RD | ib(11'h450));
		idle();
		ul(FAC_PASSWORD ^ 32'h0000_0001, 1'b0);
		ul(FAC_PASSWORD, 1'b1);
		rq(SRC_SPI, OP_WRITE, 11'h5C1, d, E_OK);
		rq(SRC_SPI, OP_READ, 11'h441, 8'h00, E_RD | d);
		rq(SRC_SPI, OP_WRITE, 11'h645, d, E_OK);
		rq(SRC_SPI, OP_READ, 11'h645, 8'h00, E_RD);
		rq(SRC_SPI, OP_WRITE, 11'h745, d, E_OK);
		rq(SRC_SPI, OP_READ, 11'h77F, 8'h00, E_RD);
		rq(SRC_RFID, OP_WRITE, 11'h450, d, E_PW);
		rq(SRC_RFID, OP_LOCK, 11'h000, 8'h0A, E_OK);
		rq(SRC_RFID, OP_READ, 11'h461, 8'h00, E_RD);
		idle();
		repeat (4) @(negedge clk_i);
		chk_byte("lock byte", ib(11'h461) | 8'h04, mal_mem_model_i.mem[11'h461]);
		chk_byte("mirror byte", d, mal_mem_model_i.mem[11'h645]);
		app_block_count_i = 8'hFF;
		gr(3'b010);
		rq(SRC_RFID, OP_WRITE, 11'h3FF, d, E_REF);
		idle();
		gr(3'b001);
		rq(SRC_RFID, OP_WRITE, 11'h3FF, d, E_OK);
		idle();
		repeat (6) @(negedge clk_i);
		chk_flag("all answered", 1'b1, exp_q.size() == 0);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		chk_byte("grants again", 8'h00, {5'h00, grants_o});
		chk_flag("fac_open again", 1'b0, fac_open_o);
		chk_flag("boot_busy again", 1'b1, boot_busy_o);
		complete_run();
	end
endmodule
